// >>> design/scg_gate_sel.sv
// scg_gate_sel: picks the gating word that applies in the current power state
// assumes sleep and deep-sleep indications come from logic on the same clock
`include "scg_params.svh"

module scg_gate_sel
  import scg_pkg::*;
(
  // gating words
  input  wire logic [31:0] run_gate,
  input  wire logic [31:0] sleep_gate,
  input  wire logic [31:0] deep_gate,
  // power state
  input  wire logic        auto_gate,
  input  wire logic        cpu_sleep,
  input  wire logic        cpu_deep_sleep,
  // selection
  output scg_mode_t        sel_mode,
  output logic      [31:0] sel_gate
);

  // ==========================================
  // selection
  always_comb begin
    sel_mode = scg_mode_run;
    if (auto_gate && cpu_deep_sleep) begin
      sel_mode = scg_mode_deep;
    end else if (auto_gate && cpu_sleep) begin
      sel_mode = scg_mode_sleep;
    end
  end

  always_comb begin
    case (sel_mode)
      scg_mode_sleep: sel_gate = sleep_gate;
      scg_mode_deep:  sel_gate = deep_gate;
      default:        sel_gate = run_gate;
    endcase
  end

endmodule : scg_gate_sel

// >>> design/scg_params.svh
// scg_params.svh: offsets, field positions, reset values and timing counts
// assumes inclusion by each design module of the sleep clock gating block
`ifndef SCG_PARAMS_SVH
`define SCG_PARAMS_SVH

// ==========================================
// address map (byte offsets from the base)
`define SCG_BASE_ADDR   32'h400FE000
`define SCG_OFS_CFG     12'h060
`define SCG_OFS_RUN     12'h100
`define SCG_OFS_SLEEP   12'h110
`define SCG_OFS_DEEP    12'h120
`define SCG_OFS_STAT    12'h140
`define SCG_OFS_MASK    12'h144

// ==========================================
// gating register layout
`define SCG_BIT_WDT     3
`define SCG_BIT_HIB     6
`define SCG_BIT_CONV    16
`define SCG_SPD_LSB     8
`define SCG_SPD_MSB     9
`define SCG_GATE_RST    32'h00000040
`define SCG_GATE_WMASK  32'h00010348
`define SCG_CFG_ACG_BIT 0
`define SCG_IRQ_FAULT   0
`define SCG_IRQ_MODE    1

// ==========================================
// avalon responses
`define SCG_RESP_OK     2'h0
`define SCG_RESP_ERR    2'h2

// ==========================================
// converter sample periods
`define SCG_CLK_NS      10
`define SCG_T500K_NS    2000
`define SCG_T250K_NS    4000
`define SCG_T125K_NS    8000
`define SCG_CYC_500K    10'((`SCG_T500K_NS) / (`SCG_CLK_NS))
`define SCG_CYC_250K    10'((`SCG_T250K_NS) / (`SCG_CLK_NS))
`define SCG_CYC_125K    10'((`SCG_T125K_NS) / (`SCG_CLK_NS))

`endif

// >>> design/scg_pkg.sv
// scg_pkg: types shared by the sleep clock gating block
// assumes nothing beyond a SystemVerilog compiler
package scg_pkg;

  // power state whose gating register drives the unit clocks
  typedef enum logic [1:0] {
    scg_mode_run,
    scg_mode_sleep,
    scg_mode_deep
  } scg_mode_t;

  // converter sample speed field encoding
  typedef enum logic [1:0] {
    scg_spd_125k,
    scg_spd_250k,
    scg_spd_500k,
    scg_spd_rsvd
  } scg_speed_t;

endpackage : scg_pkg

// >>> design/scg_top.sv
// scg_top: run, sleep and deep-sleep clock gating registers and unit clock enables
// assumes one 100 MHz clock shared with the Avalon-MM master and the unit fabric
//
// What this block does
// - a gating bit at one gives its unit a clock so that it runs normally.
// - a gating bit at zero stops the unit clock and any access to that unit faults.
// - every gating bit resets to zero except the hibernation bit, so the word resets to 0x40.
// - the sleep gating register is a 32-bit word at offset 0x110 of the system control base.
// - separate run, sleep and deep-sleep gating registers each serve their power state.
// - the sleep gating registers apply only while the automatic gating select is set.
// - hibernation bit 6, watchdog bit 3 and speed bits 9:8 are writable, other low bits read 0.
// - bit 16 gates the converter clock, and converter accesses fault while it is zero.
// - the speed field selects 500K, 250K or 125K samples per second for codes 2, 1 and 0.
//
// Design decision made here: the Avalon-MM register port.
`include "scg_params.svh"

module scg_top
  import scg_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // avalon-mm slave
  input  wire logic [11:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic      [1:0]  avs_response,
  output logic             avs_waitrequest,
  // processor power state
  input  wire logic        cpu_sleep,
  input  wire logic        cpu_deep_sleep,
  // unit access strobes: 0 watchdog, 1 hibernation, 2 converter
  input  wire logic [2:0]  unit_access,
  // unit clock controls
  output logic      [2:0]  unit_clk_en,
  output logic      [2:0]  unit_bus_fault,
  output logic      [1:0]  conv_sample_speed,
  output logic      [9:0]  conv_sample_cycles,
  // interrupt
  output logic             irq
);

  // ==========================================
  // functions
  function automatic logic [31:0] scg_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return m;
  endfunction : scg_merge

  // a speed above the top rate is held at the top rate
  function automatic logic [31:0] scg_gate_wr(input logic [31:0] old,
                                              input logic [31:0] wd,
                                              input logic [3:0]  be);
    logic [31:0] v;
    v = scg_merge(old, wd, be) & `SCG_GATE_WMASK;
    if (v[`SCG_SPD_MSB:`SCG_SPD_LSB] == 2'h3) begin
      v[`SCG_SPD_MSB:`SCG_SPD_LSB] = 2'h2;
    end
    return v;
  endfunction : scg_gate_wr

  function automatic logic [9:0] scg_period(input logic [1:0] spd);
    case (scg_speed_t'(spd))
      scg_spd_500k: scg_period = `SCG_CYC_500K;
      scg_spd_250k: scg_period = `SCG_CYC_250K;
      default:      scg_period = `SCG_CYC_125K;
    endcase
  endfunction : scg_period

  function automatic logic [2:0] scg_units(input logic [31:0] g);
    return {g[`SCG_BIT_CONV], g[`SCG_BIT_HIB], g[`SCG_BIT_WDT]};
  endfunction : scg_units

  // ==========================================
  // state
  logic [31:0] run_gate;
  logic [31:0] sleep_gate;
  logic [31:0] deep_gate;
  logic        auto_gate;
  logic [1:0]  irq_status;
  logic [1:0]  irq_mask;
  scg_mode_t   mode_q;

  logic [31:0] next_run_gate;
  logic [31:0] next_sleep_gate;
  logic [31:0] next_deep_gate;
  logic        next_auto_gate;
  logic [1:0]  next_irq_status;
  logic [1:0]  next_irq_mask;
  logic [31:0] next_readdata;
  logic [1:0]  next_response;
  logic        next_waitrequest;
  logic [2:0]  next_unit_clk_en;
  logic [2:0]  next_unit_bus_fault;
  logic [1:0]  next_speed;
  logic [9:0]  next_cycles;
  logic        next_irq;

  scg_mode_t   sel_mode;
  logic [31:0] sel_gate;
  logic        req;
  logic        wr_done;
  logic        hit;
  logic [31:0] rd_mux;
  logic [1:0]  events;

  // ==========================================
  // gating selection per power state
  scg_gate_sel u_sel (
    .run_gate       (run_gate),
    .sleep_gate     (sleep_gate),
    .deep_gate      (deep_gate),
    .auto_gate      (auto_gate),
    .cpu_sleep      (cpu_sleep),
    .cpu_deep_sleep (cpu_deep_sleep),
    .sel_mode       (sel_mode),
    .sel_gate       (sel_gate)
  );

  // ==========================================
  // register read decode
  always_comb begin
    hit    = 1'b1;
    rd_mux = 32'h00000000;
    case (avs_address)
      `SCG_OFS_RUN:   rd_mux = run_gate;
      `SCG_OFS_SLEEP: rd_mux = sleep_gate;
      `SCG_OFS_DEEP:  rd_mux = deep_gate;
      `SCG_OFS_CFG:   rd_mux[`SCG_CFG_ACG_BIT] = auto_gate;
      `SCG_OFS_STAT:  rd_mux[1:0] = irq_status;
      `SCG_OFS_MASK:  rd_mux[1:0] = irq_mask;
      default:        hit = 1'b0;
    endcase
  end

  // ==========================================
  // bus handshake and register writes
  // one idle cycle of waitrequest per access keeps readdata a plain flop
  always_comb begin
    req              = avs_read || avs_write;
    wr_done          = avs_write && !avs_waitrequest;
    next_waitrequest = !(req && avs_waitrequest);
    next_readdata    = avs_readdata;
    next_response    = avs_response;
    next_run_gate    = run_gate;
    next_sleep_gate  = sleep_gate;
    next_deep_gate   = deep_gate;
    next_auto_gate   = auto_gate;
    next_irq_mask    = irq_mask;
    if (req && avs_waitrequest) begin
      next_readdata = avs_read ? rd_mux : 32'h00000000;
      next_response = hit ? `SCG_RESP_OK : `SCG_RESP_ERR;
    end
    if (wr_done) begin
      case (avs_address)
        `SCG_OFS_RUN: begin
          next_run_gate = scg_gate_wr(run_gate, avs_writedata, avs_byteenable);
        end
        `SCG_OFS_SLEEP: begin
          next_sleep_gate = scg_gate_wr(sleep_gate, avs_writedata, avs_byteenable);
        end
        `SCG_OFS_DEEP: begin
          next_deep_gate = scg_gate_wr(deep_gate, avs_writedata, avs_byteenable);
        end
        `SCG_OFS_CFG: begin
          if (avs_byteenable[0]) begin
            next_auto_gate = avs_writedata[`SCG_CFG_ACG_BIT];
          end
        end
        `SCG_OFS_MASK: begin
          if (avs_byteenable[0]) begin
            next_irq_mask = avs_writedata[1:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ==========================================
  // unit clocks, faults and converter rate
  always_comb begin
    next_unit_clk_en    = scg_units(sel_gate);
    next_unit_bus_fault = unit_access & ~unit_clk_en;
    next_speed          = sel_gate[`SCG_SPD_MSB:`SCG_SPD_LSB];
    next_cycles         = scg_period(next_speed);
  end

  // ==========================================
  // interrupt status, set wins over a write-one clear
  always_comb begin
    events                = 2'b00;
    events[`SCG_IRQ_FAULT] = |next_unit_bus_fault;
    events[`SCG_IRQ_MODE]  = sel_mode != mode_q;
    next_irq_status       = irq_status;
    if (wr_done && avs_address == `SCG_OFS_STAT && avs_byteenable[0]) begin
      next_irq_status = irq_status & ~avs_writedata[1:0];
    end
    next_irq_status = next_irq_status | events;
    next_irq        = |(next_irq_status & next_irq_mask);
  end

  // ==========================================
  // registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      run_gate           <= `SCG_GATE_RST;
      sleep_gate         <= `SCG_GATE_RST;
      deep_gate          <= `SCG_GATE_RST;
      auto_gate          <= 1'b0;
      irq_status         <= 2'b00;
      irq_mask           <= 2'b00;
      mode_q             <= scg_mode_run;
      avs_readdata       <= 32'h00000000;
      avs_response       <= `SCG_RESP_OK;
      avs_waitrequest    <= 1'b1;
      unit_clk_en        <= 3'h2;
      unit_bus_fault     <= 3'h0;
      conv_sample_speed  <= 2'h0;
      conv_sample_cycles <= `SCG_CYC_125K;
      irq                <= 1'b0;
    end else begin
      run_gate           <= next_run_gate;
      sleep_gate         <= next_sleep_gate;
      deep_gate          <= next_deep_gate;
      auto_gate          <= next_auto_gate;
      irq_status         <= next_irq_status;
      irq_mask           <= next_irq_mask;
      mode_q             <= sel_mode;
      avs_readdata       <= next_readdata;
      avs_response       <= next_response;
      avs_waitrequest    <= next_waitrequest;
      unit_clk_en        <= next_unit_clk_en;
      unit_bus_fault     <= next_unit_bus_fault;
      conv_sample_speed  <= next_speed;
      conv_sample_cycles <= next_cycles;
      irq                <= next_irq;
    end
  end

  // ==========================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  logic post_rst;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      post_rst <= 1'b0;
    end else begin
      post_rst <= 1'b1;
    end
  end

  sequence s_sleep_wr;
    avs_write && !avs_waitrequest && avs_address == `SCG_OFS_SLEEP && avs_byteenable == 4'hF;
  endsequence

  sequence s_run_state;
    !auto_gate || !(cpu_sleep || cpu_deep_sleep);
  endsequence

  sequence s_sleep_state;
    auto_gate && cpu_sleep && !cpu_deep_sleep;
  endsequence

  property p_reset_word;
    !post_rst |-> sleep_gate == `SCG_GATE_RST && unit_clk_en == 3'h2;
  endproperty
  a_reset_word: assert property (p_reset_word) else $error("gating word not at reset value");

  property p_clock_on;
    s_sleep_state |=> unit_clk_en == scg_units($past(sleep_gate));
  endproperty
  a_clock_on: assert property (p_clock_on) else $error("sleep gating not applied");

  property p_fault;
    unit_access[0] && !unit_clk_en[0] |=> unit_bus_fault[0] ##1 irq_status[`SCG_IRQ_FAULT];
  endproperty
  a_fault: assert property (p_fault) else $error("gated watchdog access did not fault");

  property p_no_fault;
    unit_bus_fault != 3'h0 |-> ($past(unit_access) & ~$past(unit_clk_en)) == unit_bus_fault;
  endproperty
  a_no_fault: assert property (p_no_fault) else $error("fault without gated access");

  property p_sleep_write;
    s_sleep_wr |=> sleep_gate[`SCG_BIT_CONV] == $past(avs_writedata[`SCG_BIT_CONV])
               && sleep_gate[`SCG_BIT_WDT] == $past(avs_writedata[`SCG_BIT_WDT]);
  endproperty
  a_sleep_write: assert property (p_sleep_write) else $error("sleep word write lost");

  property p_reserved;
    (sleep_gate & ~`SCG_GATE_WMASK) == 32'h00000000 && (run_gate & ~`SCG_GATE_WMASK) == 32'h00000000;
  endproperty
  a_reserved: assert property (p_reserved) else $error("read-only gating bit set");

  property p_run_state;
    s_run_state |=> unit_clk_en == scg_units($past(run_gate)) && mode_q == scg_mode_run;
  endproperty
  a_run_state: assert property (p_run_state) else $error("sleep word used outside sleep");

  property p_deep_state;
    auto_gate && cpu_deep_sleep |=> unit_clk_en == scg_units($past(deep_gate));
  endproperty
  a_deep_state: assert property (p_deep_state) else $error("deep-sleep word not applied");

  property p_converter;
    unit_clk_en[2] |-> $past(sel_gate[`SCG_BIT_CONV]);
  endproperty
  a_converter: assert property (p_converter) else $error("converter clocked while gated");

  property p_rate;
    conv_sample_speed == 2'h2 |-> conv_sample_cycles == 10'h0C8;
  endproperty
  a_rate: assert property (p_rate) else $error("500K rate period wrong");

  property p_rate_slow;
    conv_sample_speed == 2'h0 |-> conv_sample_cycles == 10'h320;
  endproperty
  a_rate_slow: assert property (p_rate_slow) else $error("125K rate period wrong");

  property p_answer;
    req && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_answer: assert property (p_answer) else $error("bus request not answered in one cycle");

endmodule : scg_top

// >>> sim/sleep_mode_clock_gating_tb_top.sv
// sleep_mode_clock_gating_tb_top: self-checking bench for the clock gating block
// assumes scg_top, scg_pkg and scg_params.svh from design/ are compiled first
`include "scg_params.svh"

module sleep_mode_clock_gating_tb_top
  import scg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  // ==========================================
  // signals
  logic        clk;
  logic        rstn;
  logic [11:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic [1:0]  avs_response;
  logic        avs_waitrequest;
  logic        cpu_sleep;
  logic        cpu_deep_sleep;
  logic [2:0]  unit_access;
  logic [2:0]  unit_clk_en;
  logic [2:0]  unit_bus_fault;
  logic [1:0]  conv_sample_speed;
  logic [9:0]  conv_sample_cycles;
  logic        irq;
  int          failures;
  int          n_checks;

  scg_top i_dut (
    .clk                (clk),
    .rstn               (rstn),
    .avs_address        (avs_address),
    .avs_read           (avs_read),
    .avs_write          (avs_write),
    .avs_writedata      (avs_writedata),
    .avs_byteenable     (avs_byteenable),
    .avs_readdata       (avs_readdata),
    .avs_response       (avs_response),
    .avs_waitrequest    (avs_waitrequest),
    .cpu_sleep          (cpu_sleep),
    .cpu_deep_sleep     (cpu_deep_sleep),
    .unit_access        (unit_access),
    .unit_clk_en        (unit_clk_en),
    .unit_bus_fault     (unit_bus_fault),
    .conv_sample_speed  (conv_sample_speed),
    .conv_sample_cycles (conv_sample_cycles),
    .irq                (irq)
  );

  // ==========================================
  // clock, shared tasks
  always #5 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one avalon access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) failures++;
    rd = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic [1:0]  rsp;
    bus(1'b1, a, d, rd, rsp);
  endtask : wr

  task automatic rd_chk(input string what, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic [1:0]  rsp;
    bus(1'b0, a, 32'h00000000, rd, rsp);
    chk(what, exp, rd);
    chk({what, " resp"}, {30'h0, `SCG_RESP_OK}, {30'h0, rsp});
  endtask : rd_chk

  // the outputs follow a word change one edge later
  task automatic out_chk(input logic [2:0] en, input logic [1:0] spd, input logic [9:0] cyc);
    repeat (2) @(posedge clk);
    chk("unit_clk_en", {29'h0, en}, {29'h0, unit_clk_en});
    chk("speed", {30'h0, spd}, {30'h0, conv_sample_speed});
    chk("cycles", {22'h0, cyc}, {22'h0, conv_sample_cycles});
  endtask : out_chk

  // one access strobe; the fault pulse stands for the single cycle after it
  task automatic acc_chk(input string what, input logic [2:0] acc, input logic [2:0] exp);
    @(posedge clk);
    unit_access <= acc;
    @(posedge clk);
    unit_access <= 3'b000;
    @(posedge clk);
    chk(what, {29'h0, exp}, {29'h0, unit_bus_fault});
  endtask : acc_chk

  // ==========================================
  // scenarios
  task automatic t_reset;
    logic [31:0] rd;
    logic [1:0]  rsp;
    out_chk(3'b010, 2'h0, `SCG_CYC_125K);
    rd_chk("sleep word", `SCG_OFS_SLEEP, `SCG_GATE_RST);
    rd_chk("run word", `SCG_OFS_RUN, `SCG_GATE_RST);
    rd_chk("deep word", `SCG_OFS_DEEP, `SCG_GATE_RST);
    chk("irq", 32'h0, {31'h0, irq});
    // reserved low bits read back zero; speed code 3 is held at the top rate
    wr(`SCG_OFS_SLEEP, 32'h0001FFFF);
    rd_chk("sleep writable", `SCG_OFS_SLEEP, 32'h00010248);
    bus(1'b0, 12'h200, 32'h0, rd, rsp);
    chk("unmapped data", 32'h0, rd);
    chk("unmapped resp", {30'h0, `SCG_RESP_ERR}, {30'h0, rsp});
    $display("test reset done");
  endtask : t_reset

  task automatic t_select;
    wr(`SCG_OFS_RUN, 32'h00000000);
    out_chk(3'b000, 2'h0, `SCG_CYC_125K);
    acc_chk("gated access", 3'b111, 3'b111);
    wr(`SCG_OFS_SLEEP, 32'h00010148);
    cpu_sleep <= 1'b1;
    out_chk(3'b000, 2'h0, `SCG_CYC_125K);
    wr(`SCG_OFS_CFG, 32'h00000001);
    out_chk(3'b111, 2'h1, `SCG_CYC_250K);
    wr(`SCG_OFS_DEEP, 32'h00000108);
    cpu_deep_sleep <= 1'b1;
    out_chk(3'b001, 2'h1, `SCG_CYC_250K);
    cpu_sleep      <= 1'b0;
    cpu_deep_sleep <= 1'b0;
    out_chk(3'b000, 2'h0, `SCG_CYC_125K);
    wr(`SCG_OFS_CFG, 32'h00000000);
    $display("test select done");
  endtask : t_select

  task automatic t_speed;
    logic [1:0] s;
    for (int c = 0; c < 4; c++) begin
      s = (c > 2) ? 2'h2 : 2'(c);
      wr(`SCG_OFS_RUN, 32'h00010000 | (32'(c) << 8));
      out_chk(3'b100, s, 10'(`SCG_CYC_125K >> s));
      rd_chk("speed field", `SCG_OFS_RUN, 32'h00010000 | (32'(s) << 8));
    end
    $display("test speed done");
  endtask : t_speed

  task automatic t_fault;
    wr(`SCG_OFS_STAT, 32'h00000003);
    wr(`SCG_OFS_MASK, 32'h00000001);
    acc_chk("fault pulse", 3'b001, 3'b001);
    @(posedge clk);
    chk("fault end", 32'h0, {29'h0, unit_bus_fault});
    chk("irq set", 32'h1, {31'h0, irq});
    rd_chk("status", `SCG_OFS_STAT, 32'h00000001);
    wr(`SCG_OFS_STAT, 32'h00000001);
    @(posedge clk);
    chk("irq clear", 32'h0, {31'h0, irq});
    acc_chk("clocked access", 3'b100, 3'b000);
    wr(`SCG_OFS_MASK, 32'h00000002);
    wr(`SCG_OFS_CFG, 32'h00000001);
    cpu_sleep <= 1'b1;
    repeat (3) @(posedge clk);
    chk("mode irq", 32'h1, {31'h0, irq});
    cpu_sleep <= 1'b0;
    repeat (3) @(posedge clk);
    wr(`SCG_OFS_STAT, 32'h00000003);
    @(posedge clk);
    chk("mode irq clear", 32'h0, {31'h0, irq});
    $display("test fault done");
  endtask : t_fault

  // ==========================================
  // closing
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : results

  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    avs_address = 12'h000;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    cpu_sleep = 1'b0;
    cpu_deep_sleep = 1'b0;
    unit_access = 3'b000;
    failures = 0;
    n_checks = 0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_select();
    t_speed();
    t_fault();
    results();
  end

  // hang guard, far beyond the hundred or so cycles the tests take
  initial begin
    #200000;
    failures++;
    results();
  end

endmodule : sleep_mode_clock_gating_tb_top
